// ===== usb_irq_pkg.sv
// usb irq flag and frame number constants, types
// assumes an 8-bit register port and one 100 MHz clock
package usb_irq_pkg;
  // --------------------------------------------------
  // register offsets
  // --------------------------------------------------
  localparam logic [7:0] OFS_IN_FLAGS = 8'h02;
  localparam logic [7:0] OFS_OUT_FLAGS = 8'h04;
  localparam logic [7:0] OFS_CM_FLAGS = 8'h06;
  localparam logic [7:0] OFS_IN_EN = 8'h07;
  localparam logic [7:0] OFS_OUT_EN = 8'h08;
  localparam logic [7:0] OFS_CM_EN = 8'h0b;
  localparam logic [7:0] OFS_FRAME_LOW = 8'h0c;
  localparam logic [7:0] OFS_FRAME_HIGH = 8'h0d;
  localparam logic [7:0] OFS_SUSP_CTRL = 8'h0e;
  // --------------------------------------------------
  // field layout and reset values
  // --------------------------------------------------
  localparam int SOF_BIT = 3;
  localparam int RST_BIT = 2;
  localparam int RSU_BIT = 1;
  localparam int SUS_BIT = 0;
  localparam int SUSMODE_BIT = 1;
  localparam int SUSP_DETECT_BIT = 0;
  localparam logic [3:0] FLAGS_RST = 4'h0;
  localparam logic [3:0] IN_EN_RST = 4'hf;
  localparam logic [3:0] OUT_EN_RST = 4'he;
  localparam logic [3:0] CM_EN_RST = 4'h6;
  localparam logic [3:0] OUT_VALID = 4'he;
  localparam logic [10:0] FRAME_RST = 11'h000;
  localparam logic [7:0] DATA_ZERO = 8'h00;
  // --------------------------------------------------
  // timing
  // --------------------------------------------------
  localparam int CLK_NS = 10;
  localparam int FRAME_NS = 1000000;
  localparam int FRAME_CYC = FRAME_NS / CLK_NS;
  // --------------------------------------------------
  // types
  // --------------------------------------------------
  typedef enum logic [1:0] {
    ST_ACTIVE = 2'b01,
    ST_SUSPENDED = 2'b10
  } susp_state_e;
  typedef struct packed {
    logic sof;
    logic bus_reset;
    logic resume;
    logic suspend;
  } bus_evt_s;
endpackage : usb_irq_pkg

// ===== usb_function_irq_flags_frame.sv
// usb function interrupt flags, enables and frame number registers
// assumes event pulses from the serial engine on the same clock
`timescale 1ns/1ps
module usb_function_irq_flags_frame
  import usb_irq_pkg::*;
#(
  parameter int FRAME_CYCLES = FRAME_CYC
) (
  input wire logic CLK_SYS,
  input wire logic RST_N,
  input wire logic [7:0] ADDR,
  input wire logic [7:0] WDATA,
  input wire logic WR,
  input wire logic RD,
  output logic [7:0] RDATA,
  input wire logic SOF_VALID,
  input wire logic [10:0] SOF_FRAME,
  input wire bus_evt_s BUS_EVT,
  input wire logic [3:0] IN_EVT,
  input wire logic [3:1] OUT_EVT,
  output logic SUSPENDED,
  output logic IRQ
);
  // --------------------------------------------------
  // state
  // --------------------------------------------------
  logic [10:0] frame_reg;
  logic [3:0] in_flags_reg, in_flags_next;
  logic [3:0] out_flags_reg, out_flags_next;
  logic [3:0] cm_flags_reg, cm_flags_next;
  logic [3:0] in_en_reg, out_en_reg, cm_en_reg;
  logic susp_en_reg;
  logic resume_seen_reg, resume_seen_next;
  logic sof_armed_reg;
  logic [16:0] sof_timer_reg, sof_timer_next;
  logic [7:0] rdata_reg, rdata_next;
  susp_state_e state_reg, state_next;
  localparam logic [16:0] TIMER_LOAD = 17'(FRAME_CYCLES - 1);
  localparam logic [16:0] TIMER_ZERO = 17'h00000;

  // --------------------------------------------------
  // address decode
  // --------------------------------------------------
  wire sel_in = (ADDR == OFS_IN_FLAGS);
  wire sel_out = (ADDR == OFS_OUT_FLAGS);
  wire sel_cm = (ADDR == OFS_CM_FLAGS);
  wire sel_in_en = (ADDR == OFS_IN_EN);
  wire sel_out_en = (ADDR == OFS_OUT_EN);
  wire sel_cm_en = (ADDR == OFS_CM_EN);
  wire sel_flo = (ADDR == OFS_FRAME_LOW);
  wire sel_fhi = (ADDR == OFS_FRAME_HIGH);
  wire sel_susp = (ADDR == OFS_SUSP_CTRL);
  wire rd_in = RD && sel_in;
  wire rd_out = RD && sel_out;
  wire rd_cm = RD && sel_cm;
  wire suspended = (state_reg == ST_SUSPENDED);

  // --------------------------------------------------
  // event sources
  // --------------------------------------------------
  // missing token timeout
  wire sof_missed = sof_armed_reg && !SOF_VALID &&
                    (sof_timer_reg == TIMER_ZERO);
  wire set_sof = SOF_VALID || sof_missed;
  wire set_rst = BUS_EVT.bus_reset;
  wire set_rsu = BUS_EVT.resume && suspended;
  wire set_sus = BUS_EVT.suspend && susp_en_reg;
  wire [3:0] cm_set = {set_sof, set_rst, set_rsu, set_sus};
  wire [3:0] out_set = {OUT_EVT, 1'b0} & OUT_VALID;

  // --------------------------------------------------
  // flag update, set wins over read clear
  // --------------------------------------------------
  // read clears whole register
  assign in_flags_next = (rd_in ? FLAGS_RST : in_flags_reg) | IN_EVT;
  assign out_flags_next = (rd_out ? FLAGS_RST : out_flags_reg) | out_set;
  assign cm_flags_next = (rd_cm ? FLAGS_RST : cm_flags_reg) | cm_set;

  // --------------------------------------------------
  // suspend mode
  // --------------------------------------------------
  assign resume_seen_next = suspended &&
                            (resume_seen_reg || BUS_EVT.resume);
  always_comb begin
    state_next = state_reg;
    case (state_reg)
      ST_ACTIVE: begin
        if (set_sus) begin
          state_next = ST_SUSPENDED;
        end
      end
      ST_SUSPENDED: begin
        if (rd_cm && resume_seen_reg) begin
          state_next = ST_ACTIVE;
        end
      end
      default: begin
        state_next = ST_ACTIVE;
      end
    endcase
  end

  // --------------------------------------------------
  // frame timer
  // --------------------------------------------------
  assign sof_timer_next = (set_sof || !sof_armed_reg) ? TIMER_LOAD :
                          sof_timer_reg - 17'h00001;

  // --------------------------------------------------
  // read data
  // --------------------------------------------------
  // read mux over all registers, unmapped offsets read zero
  always_comb begin
    rdata_next = DATA_ZERO;
    if (sel_in) begin
      rdata_next = {4'h0, in_flags_reg};
    end else if (sel_out) begin
      rdata_next = {4'h0, out_flags_reg};
    end else if (sel_cm) begin
      rdata_next = {4'h0, cm_flags_reg};
    end else if (sel_in_en) begin
      rdata_next = {4'h0, in_en_reg};
    end else if (sel_out_en) begin
      rdata_next = {4'h0, out_en_reg};
    end else if (sel_cm_en) begin
      rdata_next = {4'h0, cm_en_reg};
    end else if (sel_flo) begin
      rdata_next = frame_reg[7:0];
    end else if (sel_fhi) begin
      rdata_next = {5'h00, frame_reg[10:8]};
    end else if (sel_susp) begin
      rdata_next = {6'h00, suspended, susp_en_reg};
    end
  end

  // --------------------------------------------------
  // registers
  // --------------------------------------------------
  always_ff @(posedge CLK_SYS or negedge RST_N) begin
    if (!RST_N) begin
      in_flags_reg <= FLAGS_RST;
      out_flags_reg <= FLAGS_RST;
      cm_flags_reg <= FLAGS_RST;
      state_reg <= ST_ACTIVE;
      resume_seen_reg <= 1'b0;
      sof_timer_reg <= TIMER_LOAD;
      rdata_reg <= DATA_ZERO;
    end else begin
      in_flags_reg <= in_flags_next;
      out_flags_reg <= out_flags_next;
      cm_flags_reg <= cm_flags_next;
      state_reg <= state_next;
      resume_seen_reg <= resume_seen_next;
      sof_timer_reg <= sof_timer_next;
      rdata_reg <= RD ? rdata_next : DATA_ZERO;
    end
  end

  always_ff @(posedge CLK_SYS or negedge RST_N) begin
    if (!RST_N) begin
      frame_reg <= FRAME_RST;
    end else if (SOF_VALID) begin
      frame_reg <= SOF_FRAME;
    end
  end

  // timeout runs from a real frame until bus reset or suspend mode
  always_ff @(posedge CLK_SYS or negedge RST_N) begin
    if (!RST_N) begin
      sof_armed_reg <= 1'b0;
    end else if (BUS_EVT.bus_reset || state_next == ST_SUSPENDED) begin
      sof_armed_reg <= 1'b0;
    end else if (SOF_VALID) begin
      sof_armed_reg <= 1'b1;
    end
  end

  always_ff @(posedge CLK_SYS or negedge RST_N) begin
    if (!RST_N) begin
      in_en_reg <= IN_EN_RST;
      out_en_reg <= OUT_EN_RST;
      cm_en_reg <= CM_EN_RST;
      susp_en_reg <= 1'b0;
    end else if (WR) begin
      if (sel_in_en) begin
        in_en_reg <= WDATA[3:0];
      end else if (sel_out_en) begin
        out_en_reg <= WDATA[3:0] & OUT_VALID;
      end else if (sel_cm_en) begin
        cm_en_reg <= WDATA[3:0];
      end else if (sel_susp) begin
        susp_en_reg <= WDATA[SUSP_DETECT_BIT];
      end
    end
  end

  // --------------------------------------------------
  // outputs
  // --------------------------------------------------
  // enabled flags raise interrupt
  wire irq_any = |(in_flags_reg & in_en_reg) |
                 |(out_flags_reg & out_en_reg) |
                 |(cm_flags_reg & cm_en_reg);
  assign IRQ = irq_any;
  assign RDATA = rdata_reg;
  assign SUSPENDED = suspended;

  // --------------------------------------------------
  // assertions
  // --------------------------------------------------
  chk_frame_low: assert property (
    @(posedge CLK_SYS) disable iff (!RST_N)
    SOF_VALID ##1 !SOF_VALID ##1 (RD && sel_flo && !SOF_VALID) |=>
      RDATA == $past(SOF_FRAME[7:0], 3))
    else $error("frame low read wrong");
  chk_frame_high: assert property (
    @(posedge CLK_SYS) disable iff (!RST_N)
    SOF_VALID ##1 !SOF_VALID ##1 (RD && sel_fhi && !SOF_VALID) |=>
      RDATA[2:0] == $past(SOF_FRAME[10:8], 3))
    else $error("frame high read wrong");
  chk_high_upper_zero: assert property (
    @(posedge CLK_SYS) disable iff (!RST_N)
    RD && sel_fhi |=> RDATA[7:3] == 5'h00)
    else $error("frame high upper bits not zero");
  chk_flag_hw_only: assert property (
    @(posedge CLK_SYS) disable iff (!RST_N)
    WR && sel_in && IN_EVT == 4'h0 |=> !$rose(|in_flags_reg))
    else $error("software write set a flag");
  chk_irq_follows: assert property (
    @(posedge CLK_SYS) disable iff (!RST_N)
    ((cm_flags_reg[RST_BIT] && cm_en_reg[RST_BIT]) ||
     (in_flags_reg[0] && in_en_reg[0])) |-> IRQ)
    else $error("irq low with enabled flag");
  chk_read_clear: assert property (
    @(posedge CLK_SYS) disable iff (!RST_N)
    rd_in && IN_EVT == 4'h0 |=>
      in_flags_reg == 4'h0 && RDATA[3:0] == $past(in_flags_reg))
    else $error("in flags not cleared by read");
  chk_in_layout: assert property (
    @(posedge CLK_SYS) disable iff (!RST_N)
    IN_EVT[0] |=> in_flags_reg[0])
    else $error("control endpoint flag missed");
  chk_out_bit0: assert property (
    @(posedge CLK_SYS) disable iff (!RST_N)
    RD && sel_out |=> RDATA[0] == 1'b0 ##0 RDATA[7:4] == 4'h0)
    else $error("out flag bit 0 or upper set");
  chk_cm_upper_zero: assert property (
    @(posedge CLK_SYS) disable iff (!RST_N)
    RD && (sel_cm || sel_in) |=> RDATA[7:4] == 4'h0)
    else $error("flag upper bits not zero");
  chk_sof_flag: assert property (
    @(posedge CLK_SYS) disable iff (!RST_N)
    SOF_VALID |=> cm_flags_reg[SOF_BIT])
    else $error("frame start flag not set");
  chk_sof_synth: assert property (
    @(posedge CLK_SYS) disable iff (!RST_N)
    sof_missed |=> cm_flags_reg[SOF_BIT] &&
      sof_timer_reg == TIMER_LOAD)
    else $error("missed frame not synthesized");
  chk_reset_flag: assert property (
    @(posedge CLK_SYS) disable iff (!RST_N)
    BUS_EVT.bus_reset |=> cm_flags_reg[RST_BIT])
    else $error("bus reset flag not set");
  chk_resume_gate: assert property (
    @(posedge CLK_SYS) disable iff (!RST_N)
    $rose(cm_flags_reg[RSU_BIT]) |->
      $past(suspended) && $past(BUS_EVT.resume))
    else $error("resume flag set while awake");
  chk_suspend_gate: assert property (
    @(posedge CLK_SYS) disable iff (!RST_N)
    $rose(cm_flags_reg[SUS_BIT]) |-> $past(susp_en_reg))
    else $error("suspend flag set while disabled");
  chk_leave_suspend: assert property (
    @(posedge CLK_SYS) disable iff (!RST_N)
    suspended && resume_seen_reg && rd_cm |=> !SUSPENDED)
    else $error("suspend not left after read");
  chk_frame_atomic: assert property (
    @(posedge CLK_SYS) disable iff (!RST_N)
    $changed(frame_reg) |-> $past(SOF_VALID) &&
      frame_reg == $past(SOF_FRAME))
    else $error("frame number changed without token");
  chk_frame_capture: assert property (
    @(posedge CLK_SYS) disable iff (!RST_N)
    SOF_VALID |=> frame_reg == $past(SOF_FRAME))
    else $error("frame number not captured");
  chk_irq_masked: assert property (
    @(posedge CLK_SYS) disable iff (!RST_N)
    (in_flags_reg & in_en_reg) == 4'h0 &&
      (out_flags_reg & out_en_reg) == 4'h0 &&
      (cm_flags_reg & cm_en_reg) == 4'h0 |-> !IRQ)
    else $error("irq high with all flags masked");
  chk_out_clear: assert property (
    @(posedge CLK_SYS) disable iff (!RST_N)
    rd_out && OUT_EVT == 3'h0 |=> out_flags_reg == 4'h0)
    else $error("out flags not cleared by read");
  chk_cm_clear: assert property (
    @(posedge CLK_SYS) disable iff (!RST_N)
    rd_cm && cm_set == 4'h0 |=> cm_flags_reg == 4'h0)
    else $error("common flags not cleared by read");
  chk_out_set: assert property (
    @(posedge CLK_SYS) disable iff (!RST_N)
    OUT_EVT[1] |=> out_flags_reg[1])
    else $error("out endpoint one flag missed");
  chk_suspend_enter: assert property (
    @(posedge CLK_SYS) disable iff (!RST_N)
    set_sus && !suspended |=> SUSPENDED && cm_flags_reg[SUS_BIT])
    else $error("enabled suspend not taken");
  chk_resume_set: assert property (
    @(posedge CLK_SYS) disable iff (!RST_N)
    BUS_EVT.resume && suspended |=> cm_flags_reg[RSU_BIT])
    else $error("resume while suspended not flagged");
  chk_stay_suspended: assert property (
    @(posedge CLK_SYS) disable iff (!RST_N)
    suspended && !(rd_cm && resume_seen_reg) |=> SUSPENDED)
    else $error("suspend left without wake read");
endmodule : usb_function_irq_flags_frame

// ===== tb_usb_function_irq_flags_frame.sv
// self-checking bench for the usb flag and frame number block
// assumes the usb_irq_pkg package is compiled first
`timescale 1ns/1ps
module tb_usb_function_irq_flags_frame
  import usb_irq_pkg::*;
;
  // ----------------------------------------
  // signals and instance
  // ----------------------------------------
  localparam int FC = 50;
  logic CLK_SYS = 1'b0;
  logic RST_N = 1'b0;
  logic [7:0] ADDR = 8'h00;
  logic [7:0] WDATA = 8'h00;
  logic WR = 1'b0;
  logic RD = 1'b0;
  logic [7:0] RDATA;
  logic SOF_VALID = 1'b0;
  logic [10:0] SOF_FRAME = 11'h000;
  bus_evt_s BUS_EVT = '0;
  logic [3:0] IN_EVT = 4'h0;
  logic [3:1] OUT_EVT = 3'h0;
  logic SUSPENDED;
  logic IRQ;
  int n_fail = 0;
  int checks = 0;

  usb_function_irq_flags_frame #(.FRAME_CYCLES(FC))
    i_usb_function_irq_flags_frame (
    .CLK_SYS(CLK_SYS), .RST_N(RST_N), .ADDR(ADDR), .WDATA(WDATA),
    .WR(WR), .RD(RD), .RDATA(RDATA), .SOF_VALID(SOF_VALID),
    .SOF_FRAME(SOF_FRAME), .BUS_EVT(BUS_EVT), .IN_EVT(IN_EVT),
    .OUT_EVT(OUT_EVT), .SUSPENDED(SUSPENDED), .IRQ(IRQ));

  initial begin
    forever #5 CLK_SYS = ~CLK_SYS;
  end

  // ----------------------------------------
  // tasks
  // ----------------------------------------
  task automatic chk(input logic [7:0] got, input logic [7:0] exp,
                     input string m);
    checks++;
    if (got !== exp) begin
      n_fail++;
      $display("CHECK FAILED %0t %s got %h exp %h", $time, m, got, exp);
    end
  endtask : chk

  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge CLK_SYS);
    ADDR <= a;
    WDATA <= d;
    WR <= 1'b1;
    @(posedge CLK_SYS);
    WR <= 1'b0;
  endtask : wr

  task automatic rd(input logic [7:0] a, input logic [7:0] exp);
    @(posedge CLK_SYS);
    ADDR <= a;
    RD <= 1'b1;
    @(posedge CLK_SYS);
    RD <= 1'b0;
    #1;
    chk(RDATA, exp, "read data");
  endtask : rd

  task automatic ev(input logic [3:0] i, input logic [3:1] o,
                    input logic [3:0] b, input logic s,
                    input logic [10:0] f);
    @(posedge CLK_SYS);
    IN_EVT <= i;
    OUT_EVT <= o;
    BUS_EVT <= bus_evt_s'(b);
    SOF_VALID <= s;
    SOF_FRAME <= f;
    @(posedge CLK_SYS);
    IN_EVT <= 4'h0;
    OUT_EVT <= 3'h0;
    BUS_EVT <= '0;
    SOF_VALID <= 1'b0;
    #1;
  endtask : ev

  task automatic end_of_test();
    $display("checks %0d n_fail %0d", checks, n_fail);
    if (n_fail == 0 && checks > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask : end_of_test

  initial begin
    #100000;
    n_fail++;
    end_of_test();
  end

  // ----------------------------------------
  // tests
  // ----------------------------------------
  initial begin
    repeat (3) @(posedge CLK_SYS);
    RST_N <= 1'b1;
    rd(OFS_IN_FLAGS, 8'h00);
    rd(OFS_OUT_FLAGS, 8'h00);
    rd(OFS_CM_FLAGS, 8'h00);
    rd(OFS_FRAME_LOW, 8'h00);
    rd(OFS_FRAME_HIGH, 8'h00);
    rd(OFS_IN_EN, 8'h0f);
    rd(OFS_OUT_EN, 8'h0e);
    rd(OFS_CM_EN, 8'h06);
    rd(8'h30, 8'h00);
    chk({7'h00, IRQ}, 8'h00, "irq idle");
    $display("test reset values done");
    wr(OFS_IN_FLAGS, 8'hff);
    ev(4'hf, 3'h0, 4'h0, 1'b0, 11'h000);
    chk({7'h00, IRQ}, 8'h01, "irq in");
    rd(OFS_IN_FLAGS, 8'h0f);
    rd(OFS_IN_FLAGS, 8'h00);
    chk({7'h00, IRQ}, 8'h00, "irq cleared");
    ev(4'h0, 3'h7, 4'h0, 1'b0, 11'h000);
    wr(OFS_OUT_FLAGS, 8'hff);
    rd(OFS_OUT_FLAGS, 8'h0e);
    rd(OFS_OUT_FLAGS, 8'h00);
    $display("test endpoint flags done");
    ev(4'h0, 3'h0, 4'h0, 1'b1, 11'h5a3);
    chk({7'h00, IRQ}, 8'h00, "sof masked");
    rd(OFS_FRAME_LOW, 8'ha3);
    wr(OFS_FRAME_HIGH, 8'hff);
    rd(OFS_FRAME_HIGH, 8'h05);
    rd(OFS_CM_FLAGS, 8'h08);
    ev(4'h0, 3'h0, 4'h0, 1'b1, 11'h7ff);
    rd(OFS_FRAME_HIGH, 8'h07);
    wr(OFS_FRAME_LOW, 8'h00);
    rd(OFS_FRAME_LOW, 8'hff);
    rd(OFS_CM_FLAGS, 8'h08);
    repeat (FC + 10) @(posedge CLK_SYS);
    rd(OFS_CM_FLAGS, 8'h08);
    ev(4'h0, 3'h0, 4'h4, 1'b0, 11'h000);
    chk({7'h00, IRQ}, 8'h01, "irq reset");
    repeat (FC + 10) @(posedge CLK_SYS);
    rd(OFS_CM_FLAGS, 8'h04);
    repeat (FC + 10) @(posedge CLK_SYS);
    rd(OFS_CM_FLAGS, 8'h00);
    $display("test frame and bus flags done");
    ev(4'h0, 3'h0, 4'h1, 1'b0, 11'h000);
    rd(OFS_CM_FLAGS, 8'h00);
    ev(4'h0, 3'h0, 4'h2, 1'b0, 11'h000);
    rd(OFS_CM_FLAGS, 8'h00);
    wr(OFS_SUSP_CTRL, 8'h01);
    ev(4'h0, 3'h0, 4'h1, 1'b0, 11'h000);
    chk({7'h00, SUSPENDED}, 8'h01, "suspend entered");
    chk({7'h00, IRQ}, 8'h00, "suspend masked");
    rd(OFS_SUSP_CTRL, 8'h03);
    rd(OFS_CM_FLAGS, 8'h01);
    ev(4'h0, 3'h0, 4'h2, 1'b0, 11'h000);
    chk({7'h00, IRQ}, 8'h01, "irq resume");
    rd(OFS_CM_FLAGS, 8'h02);
    @(posedge CLK_SYS);
    #1;
    chk({7'h00, SUSPENDED}, 8'h00, "suspend left");
    $display("test suspend done");
    wr(OFS_CM_EN, 8'hff);
    rd(OFS_CM_EN, 8'h0f);
    wr(OFS_OUT_EN, 8'hff);
    rd(OFS_OUT_EN, 8'h0e);
    ev(4'h0, 3'h0, 4'h0, 1'b1, 11'h001);
    chk({7'h00, IRQ}, 8'h01, "irq sof");
    wr(OFS_CM_EN, 8'h00);
    wr(OFS_IN_EN, 8'h00);
    ev(4'h3, 3'h0, 4'h0, 1'b0, 11'h000);
    chk({7'h00, IRQ}, 8'h00, "all masked");
    wr(OFS_IN_EN, 8'h0f);
    #1;
    chk({7'h00, IRQ}, 8'h01, "unmasked");
    @(posedge CLK_SYS);
    RST_N <= 1'b0;
    #1;
    chk({7'h00, IRQ}, 8'h00, "irq in reset");
    repeat (3) @(posedge CLK_SYS);
    RST_N <= 1'b1;
    rd(OFS_IN_FLAGS, 8'h00);
    rd(OFS_CM_FLAGS, 8'h00);
    rd(OFS_FRAME_LOW, 8'h00);
    rd(OFS_IN_EN, 8'h0f);
    rd(OFS_CM_EN, 8'h06);
    $display("test mask and reset done");
    end_of_test();
  end
endmodule : tb_usb_function_irq_flags_frame
